//--- hdl/gateway_status_word.sv
// Gateway status word: exchange state, consistency flag, status code and byte view
`timescale 1ns/100ps
module gateway_status_word
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Configuration
   input wire logic status_enable,
   input wire gsw_pkg::gsw_mode_e mode,
   // Fieldbus link state, from a pin
   input wire logic fieldbus_online,
   // Handshake bits from the handshake engine
   input wire logic status_handshake_send,
   input wire logic status_handshake_confirm,
   // Sub-network progress and events
   input wire logic all_transactions_done,
   input wire gsw_pkg::gsw_event_s ev,
   // Input data area byte read port
   input wire logic [9:0] rd_addr,
   output logic [7:0] rd_data,
   output logic rd_hit,
   // Status word and exchange state
   output logic [15:0] status_word,
   output logic exchange_active,
   output logic offline
);
   // ----------------------------------------
   // Link input synchroniser
   // ----------------------------------------
   logic online_meta_r, online_sync_r;
   logic online_meta_nxt, online_sync_nxt;

   always_comb
   begin
      online_meta_nxt = fieldbus_online;
      online_sync_nxt = online_meta_r;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         online_meta_r <= 1'b0;
         online_sync_r <= 1'b0;
      end
      else if (clk_en)
      begin
         online_meta_r <= online_meta_nxt;
         online_sync_r <= online_sync_nxt;
      end
   end

   // ----------------------------------------
   // Exchange state machine
   // ----------------------------------------
   gsw_pkg::gsw_state_e state_r, state_nxt;
   logic consistent_r, consistent_nxt;
   logic master_mode;

   assign master_mode = (mode != gsw_pkg::MODE_GENERIC);

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         gsw_pkg::ST_OFFLINE:
            if (online_sync_r)
               state_nxt = gsw_pkg::ST_ONLINE_WAIT;
         gsw_pkg::ST_ONLINE_WAIT:
            if (!online_sync_r)
               state_nxt = gsw_pkg::ST_OFFLINE;
            else if (consistent_r || !master_mode)
               state_nxt = gsw_pkg::ST_EXCHANGING;
         gsw_pkg::ST_EXCHANGING:
            if (!online_sync_r)
               state_nxt = gsw_pkg::ST_OFFLINE;
      endcase
   end

   // ----------------------------------------
   // Data-consistent flag
   // ----------------------------------------
   // Cleared by the offline state and held clear in generic mode, so the control system sees it
   // drop before it raises its own flag; never cleared while online in a master mode.
   always_comb
   begin
      consistent_nxt = consistent_r;
      if (state_r == gsw_pkg::ST_OFFLINE)
         consistent_nxt = 1'b0;
      else if (master_mode && all_transactions_done)
         consistent_nxt = 1'b1;
      if (!master_mode)
         consistent_nxt = 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= gsw_pkg::ST_OFFLINE;
         consistent_r <= 1'b0;
      end
      else if (clk_en)
      begin
         state_r <= state_nxt;
         consistent_r <= consistent_nxt;
      end
   end

   // ----------------------------------------
   // Status code and data byte
   // ----------------------------------------
   gsw_pkg::gsw_report_s report;
   logic report_valid;
   logic [4:0] code_r, code_nxt;
   logic [7:0] data_r, data_nxt;
   logic error_open_r, error_open_nxt;

   gsw_code_select u_select
   (
      .mode(mode),
      .ev(ev),
      .report(report),
      .report_valid(report_valid)
   );

   // A later event overrides a pending clear in the same cycle
   always_comb
   begin
      code_nxt = code_r;
      data_nxt = data_r;
      error_open_nxt = error_open_r;
      if (report_valid)
      begin
         code_nxt = report.code;
         data_nxt = report.data;
         error_open_nxt = report.is_error;
      end
      else if (ev.cause_cleared && error_open_r)
      begin
         code_nxt = gsw_pkg::CODE_NO_ERROR;
         data_nxt = 8'h00;
         error_open_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         code_r <= gsw_pkg::CODE_RESET;
         data_r <= gsw_pkg::DATA_RESET;
         error_open_r <= 1'b0;
      end
      else if (clk_en)
      begin
         code_r <= code_nxt;
         data_r <= data_nxt;
         error_open_r <= error_open_nxt;
      end
   end

   // ----------------------------------------
   // Word assembly and byte read port
   // ----------------------------------------
   logic [15:0] word;
   logic [15:0] word_nxt;
   logic [7:0] rd_data_nxt;
   logic rd_hit_nxt;

   always_comb
   begin
      word = {3'b000, code_r, data_r};
      word[gsw_pkg::BIT_HS_SEND] = status_handshake_send;
      word[gsw_pkg::BIT_HS_CONFIRM] = status_handshake_confirm;
      word[gsw_pkg::BIT_CONSISTENT] = consistent_r;
      word_nxt = status_enable ? word : 16'h0000;
      rd_hit_nxt = 1'b0;
      rd_data_nxt = 8'h00;
      if (status_enable)
      begin
         if (rd_addr == gsw_pkg::STATUS_BYTE_HI)
         begin
            rd_hit_nxt = 1'b1;
            rd_data_nxt = word[15:8];
         end
         else if (rd_addr == gsw_pkg::STATUS_BYTE_LO)
         begin
            rd_hit_nxt = 1'b1;
            rd_data_nxt = word[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         status_word <= 16'h0000;
         rd_data <= 8'h00;
         rd_hit <= 1'b0;
         exchange_active <= 1'b0;
         offline <= 1'b1;
      end
      else if (clk_en)
      begin
         status_word <= word_nxt;
         rd_data <= rd_data_nxt;
         rd_hit <= rd_hit_nxt;
         exchange_active <= (state_nxt == gsw_pkg::ST_EXCHANGING);
         offline <= (state_nxt == gsw_pkg::ST_OFFLINE);
      end
   end
endmodule

//--- hdl/gsw_pkg.sv
// Package of constants and carrier types for the gateway status word block
package gsw_pkg;
   localparam logic [9:0] STATUS_BYTE_HI = 10'h000;
   localparam logic [9:0] STATUS_BYTE_LO = 10'h001;
   localparam int BIT_HS_SEND = 15;
   localparam int BIT_HS_CONFIRM = 14;
   localparam int BIT_CONSISTENT = 13;
   localparam logic [4:0] CODE_00 = 5'h00;
   localparam logic [4:0] CODE_01 = 5'h01;
   localparam logic [4:0] CODE_02 = 5'h02;
   localparam logic [4:0] CODE_03 = 5'h03;
   localparam logic [4:0] CODE_04 = 5'h04;
   localparam logic [4:0] CODE_NO_ERROR = 5'h1F;
   localparam logic [4:0] CODE_RESET = 5'h1F;
   localparam logic [7:0] DATA_RESET = 8'h00;

   typedef enum logic [1:0] {MODE_MASTER, MODE_ALT_MASTER, MODE_GENERIC} gsw_mode_e;
   typedef enum {ST_OFFLINE, ST_ONLINE_WAIT, ST_EXCHANGING} gsw_state_e;

   // Event inputs, one-cycle strobes from the sub-network engine
   typedef struct packed
   {
      logic retrans_inc;
      logic node_missing;
      logic nodes_missing;
      logic overrun;
      logic other_error;
      logic invalid_inc;
      logic frame_error;
      logic timeout_inc;
      logic cause_cleared;
      logic [7:0] address;
      logic [7:0] count;
   } gsw_event_s;

   typedef struct packed
   {
      logic [4:0] code;
      logic [7:0] data;
      logic is_error;
   } gsw_report_s;
endpackage

//--- hdl/gsw_code_select.sv
// Status code selection from sub-network events
`timescale 1ns/100ps
module gsw_code_select
(
   // Mode and events
   input wire gsw_pkg::gsw_mode_e mode,
   input wire gsw_pkg::gsw_event_s ev,
   // Selected report
   output gsw_pkg::gsw_report_s report,
   output logic report_valid
);
   // Errors take precedence over warnings so an error is never hidden by a warning in the same cycle
   always_comb
   begin
      report = '{code: gsw_pkg::CODE_NO_ERROR, data: 8'h00, is_error: 1'b0};
      report_valid = 1'b1;
      if (mode == gsw_pkg::MODE_GENERIC)
      begin
         if (ev.invalid_inc)
            report = '{code: gsw_pkg::CODE_00, data: ev.count, is_error: 1'b1};
         else if (ev.timeout_inc)
            report = '{code: gsw_pkg::CODE_02, data: ev.count, is_error: 1'b1};
         else if (ev.other_error)
            report = '{code: gsw_pkg::CODE_04, data: 8'h00, is_error: 1'b1};
         else if (ev.frame_error)
            report = '{code: gsw_pkg::CODE_01, data: 8'h00, is_error: 1'b0};
         else if (ev.overrun)
            report = '{code: gsw_pkg::CODE_03, data: 8'h00, is_error: 1'b0};
         else
            report_valid = 1'b0;
      end
      else
      begin
         if (ev.nodes_missing)
            report = '{code: gsw_pkg::CODE_02, data: ev.count, is_error: 1'b1};
         else if (ev.node_missing)
            report = '{code: gsw_pkg::CODE_01, data: ev.address, is_error: 1'b1};
         else if (ev.other_error)
            report = '{code: gsw_pkg::CODE_04, data: ev.address, is_error: 1'b1};
         else if (ev.overrun)
            report = '{code: gsw_pkg::CODE_03, data: ev.address, is_error: 1'b0};
         else if (ev.retrans_inc)
            report = '{code: gsw_pkg::CODE_00, data: ev.count, is_error: 1'b0};
         else
            report_valid = 1'b0;
      end
   end
endmodule

//--- tb/gsw_status_assertions.sv
// Port-level checker for the gateway status word
`timescale 1ns/100ps
module gsw_status_chk
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Inputs
   input wire logic status_enable,
   input wire gsw_pkg::gsw_mode_e mode,
   input wire logic fieldbus_online,
   input wire logic status_handshake_send,
   input wire logic status_handshake_confirm,
   input wire logic all_transactions_done,
   input wire gsw_pkg::gsw_event_s ev,
   input wire logic [9:0] rd_addr,
   // Outputs
   input wire logic [7:0] rd_data,
   input wire logic rd_hit,
   input wire logic [15:0] status_word,
   input wire logic exchange_active,
   input wire logic offline
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_off; !status_enable |=> status_word == 16'h0000; endproperty
   a_off: assert property (p_off) else $error("word not zero while disabled");
   property p_hs; status_enable |=> status_word[15:14] == $past({status_handshake_send, status_handshake_confirm}); endproperty
   a_hs: assert property (p_hs) else $error("handshake bits wrong");
   property p_gen; mode == gsw_pkg::MODE_GENERIC |-> !status_word[13]; endproperty
   a_gen: assert property (p_gen) else $error("consistent bit used in generic mode");
   // Guarded by a quiet link so a legal clear in the offline state is not flagged
   property p_keep; status_word[13] && status_enable && fieldbus_online && $past(fieldbus_online, 4) |=> status_word[13]; endproperty
   a_keep: assert property (p_keep) else $error("consistent bit cleared");
   property p_hit; 1 |=> rd_hit == ($past(rd_addr) <= gsw_pkg::STATUS_BYTE_LO && $past(status_enable)); endproperty
   a_hit: assert property (p_hit) else $error("byte hit wrong");
   property p_ord; rd_hit && $stable(status_word) |-> rd_data == ($past(rd_addr[0]) ? status_word[7:0] : status_word[15:8]); endproperty
   a_ord: assert property (p_ord) else $error("byte order wrong");
   // The following cycle is also required quiet; an event or clear in it reaches status_word only after the checked cycle
   property p_miss;
      (status_enable && mode != gsw_pkg::MODE_GENERIC && ev.nodes_missing)
         ##1 (status_enable && ev[24:16] == 9'h000)
         |-> ##1 status_word[12:0] == {gsw_pkg::CODE_02, $past(ev.count, 2)};
   endproperty
   a_miss: assert property (p_miss) else $error("missing nodes report wrong");
   property p_inv;
      (status_enable && mode == gsw_pkg::MODE_GENERIC && ev.invalid_inc)
         ##1 (status_enable && ev[24:16] == 9'h000)
         |-> ##1 status_word[12:0] == {gsw_pkg::CODE_00, $past(ev.count, 2)};
   endproperty
   a_inv: assert property (p_inv) else $error("invalid counter report wrong");
   property p_clr;
      (status_enable && status_word[12:8] == gsw_pkg::CODE_02 && ev[24:16] == 9'h001 && $past(ev[24:17]) == 8'h00)
         ##1 (status_enable && ev[24:16] == 9'h000)
         |-> ##1 status_word[12:8] == gsw_pkg::CODE_NO_ERROR;
   endproperty
   a_clr: assert property (p_clr) else $error("error not followed by no error");
   property p_drop; !fieldbus_online [*6] |-> offline && !exchange_active; endproperty
   a_drop: assert property (p_drop) else $error("not offline after link loss");
endmodule

//--- tb/gsw_ctrl_reader.sv
// Control system model polling the status word byte by byte
`timescale 1ns/100ps
module gsw_ctrl_reader
(
   // Clock and link state
   input wire logic ref_clk,
   input wire logic offline,
   // Byte read port
   input wire logic [7:0] rd_data,
   output logic [9:0] rd_addr,
   // Word as the control system assembles it
   output logic [15:0] word_seen,
   // Own data-valid flag of the control word
   output logic ctrl_valid
);
   // Polls from the start without waiting for the consistent flag; address 2 lies past the word
   initial rd_addr = 10'h000;
   initial ctrl_valid = 1'b0;
   always @(posedge ref_clk)
   begin
      #1;
      if (rd_addr == 10'h000)
         word_seen[15:8] = rd_data;
      // Own flag rises only once the status flag has been seen clear while online
      if (offline)
         ctrl_valid = 1'b0;
      else if (rd_addr == 10'h000 && !rd_data[5])
         ctrl_valid = 1'b1;
      if (rd_addr == 10'h001)
         word_seen[7:0] = rd_data;
      rd_addr = (rd_addr == 10'h002) ? 10'h000 : rd_addr + 10'h001;
   end
endmodule

//--- tb/tb_gateway_status_word.sv
// Self-checking bench for the gateway status word
`timescale 1ns/100ps
module tb_gateway_status_word;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic status_enable = 1'b1;
   gsw_pkg::gsw_mode_e mode = gsw_pkg::MODE_MASTER;
   logic fieldbus_online = 1'b0;
   logic status_handshake_send = 1'b0;
   logic status_handshake_confirm = 1'b0;
   logic all_transactions_done = 1'b0;
   gsw_pkg::gsw_event_s ev = '0;
   logic [9:0] rd_addr;
   logic [7:0] rd_data;
   logic rd_hit;
   logic [15:0] status_word;
   logic exchange_active;
   logic offline;
   logic [15:0] word_seen;
   logic ctrl_valid;
   int seed = 5769;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   gateway_status_word uut (.*);
   gsw_ctrl_reader model (.*);
   // ----------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         mismatches++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (exp !== got)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Strobe k is ev bit 24-k; result is {data compared, code, data}
   function automatic logic [13:0] exp_rep(logic gen, int k, logic [7:0] a, logic [7:0] c);
      if (gen)
         return {k == 5 || k == 7, (k == 5) ? 5'h00 : (k == 6) ? 5'h01 : (k == 7) ? 5'h02 : 5'(k), c};
      return {1'b1, 5'(k), (k == 0 || k == 2) ? c : a};
   endfunction
   task automatic run_mode(gsw_pkg::gsw_mode_e m);
      logic gen;
      logic err;
      logic [13:0] e;
      gen = (m == gsw_pkg::MODE_GENERIC);
      rst = 1'b1;
      mode = m;
      fieldbus_online = 1'b0;
      tick(20);
      check("reset state", 16'h0002, 16'({offline, exchange_active}));
      check("reset word", 16'h0000, status_word);
      rst = 1'b0;
      fieldbus_online = 1'b1;
      tick(6);
      check("offline", 16'h0000, 16'(offline));
      all_transactions_done = !gen;
      tick(1);
      all_transactions_done = 1'b0;
      tick(5);
      check("exchange", 16'h0001, 16'(exchange_active));
      check("consistent", 16'(!gen), 16'(status_word[13]));
      check("own flag set", 16'h0001, 16'(ctrl_valid));
      for (int k = 0; k < 8; k++)
         if (gen ? k > 2 : k < 5)
         begin
            ev.address = 8'($random(seed));
            ev.count = 8'($random(seed));
            ev[24 - k] = 1'b1;
            tick(1);
            ev[24 - k] = 1'b0;
            tick(2);
            e = exp_rep(gen, k, ev.address, ev.count);
            err = gen ? (k == 4 || k == 5 || k == 7) : (k == 1 || k == 2 || k == 4);
            check("code", 16'(e[12:8]), 16'(status_word[12:8]));
            if (e[13])
               check("data", 16'(e[7:0]), 16'(status_word[7:0]));
            ev.cause_cleared = 1'b1;
            tick(1);
            ev.cause_cleared = 1'b0;
            tick(2);
            check("cleared", 16'(err ? 5'h1F : e[12:8]), 16'(status_word[12:8]));
         end
      status_handshake_send = 1'($random(seed));
      status_handshake_confirm = 1'($random(seed));
      repeat (30)
      begin
         ev = 25'($random(seed));
         tick(1);
      end
      ev = '0;
      tick(8);
      check("consistent kept", 16'(!gen), 16'(status_word[13]));
      check("handshake", 16'({status_handshake_send, status_handshake_confirm}), 16'(status_word[15:14]));
      check("byte view", status_word, word_seen);
      status_enable = 1'b0;
      tick(3);
      check("disabled", 16'h0000, status_word);
      status_enable = 1'b1;
      fieldbus_online = 1'b0;
      tick(8);
      check("dropped", 16'h0002, 16'({offline, exchange_active}));
      check("own flag dropped", 16'h0000, 16'(ctrl_valid));
   endtask
   initial
   begin
      run_mode(gsw_pkg::MODE_MASTER);
      run_mode(gsw_pkg::MODE_ALT_MASTER);
      run_mode(gsw_pkg::MODE_GENERIC);
      stop_test();
   end
endmodule
bind gateway_status_word gsw_status_chk u_chk (.*);
